// [hw/safety_stop_sequencer.sv]
// Emergency stop sequencing and limited-speed supervision of one drive axis
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module safety_stop_sequencer
    import safety_stop_pkg::*;
#(
    parameter int TICK = TICK_CYCLES,
    parameter int SPEED_W = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    // Stop inputs, high while the stop is open
    input wire logic nc_estop_i,
    input wire logic ext_estop_i,
    input wire logic line_estop_i,
    // Controller status
    input wire logic all_axes_stopped_i,
    input wire logic nc_overspeed_i,
    // Motor and door
    input wire logic motor_stopped_i,
    input wire logic door_state_input_i,
    input wire logic [SPEED_W-1:0] cmd_speed_i,
    input wire logic [SPEED_W-1:0] fb_speed_i,
    // Stop status
    output logic estop_o,
    output logic line_estop_o,
    output logic ext_estop_indication_o,
    // Power path
    output logic ready_o,
    output logic contactor_on_o,
    output logic torque_off_function_o,
    // Braking mode
    output logic spindle_decel_o,
    output logic servo_decel_o,
    output logic servo_dyn_brake_o,
    // Interrupt
    output logic irq_o
);

    localparam int TICK_W = $clog2(TICK + 1);

    // Parameter sanity
    if (TICK < 1 || TICK > 1048576) begin : g_bad_tick
        $error("TICK out of range");
    end
    if (SPEED_W < 1 || SPEED_W > 16) begin : g_bad_speed
        $error("SPEED_W must be 1..16");
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers and state

    seq_state_t state, next_state;
    logic [CTRL_W-1:1] ctrl;
    logic [DLY_W-1:0] servo_gate_off_delay, spindle_gate_off_delay;
    logic [SPEED_W-1:0] cmd_limit, fb_limit;
    logic [IRQ_W-1:0] irq_stat, irq_mask, irq_event;
    logic [TICK_W-1:0] tick_cnt;
    logic [DLY_W-1:0] ms_cnt, max_delay;
    logic nc_seen, ext_seen, speed_alarm, speed_trip, cmd_over, fb_over;
    logic stop_req, restart_req, confirm_drop, timeout, open_now, watch_on, wr_ctrl;

    assign wr_ctrl = wr_i && (addr_i == CTRL_ADDR);
    assign restart_req = wr_ctrl && wdata_i[CTRL_RESTART];
    // Either stop input, or a stop seen elsewhere on the line
    assign stop_req = nc_estop_i || ext_estop_i || line_estop_i;
    // Longest of the two configured gate-off delays
    assign max_delay = (servo_gate_off_delay > spindle_gate_off_delay) ?
                       servo_gate_off_delay : spindle_gate_off_delay;
    // Controller confirmation counts once its own stop was seen
    assign confirm_drop = (state == ST_STOP) && (nc_seen || nc_estop_i)
                          && all_axes_stopped_i;
    // Fallback when ready was never dropped
    assign timeout = (state == ST_STOP) && !confirm_drop && (ms_cnt >= max_delay);
    assign open_now = confirm_drop || timeout;
    // Door state comes from the drive's own input
    assign watch_on = ctrl[CTRL_SPEED_WATCH] && door_state_input_i;

    ////////////////////////////////////////////////////////////////////////
    // Stop sequencer

    // Next state
    always_comb begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (restart_req && !stop_req) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (stop_req) begin
                    next_state = ST_STOP;
                end
            end
            ST_STOP: begin
                if (open_now) begin
                    next_state = ST_OPEN;
                end
            end
            ST_OPEN: begin
                if (restart_req && !stop_req) begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_OFF;
        endcase
    end

    // State register and stop flag
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state <= ST_OFF;
            estop_o <= 1'b0;
        end else begin
            state <= next_state;
            estop_o <= (next_state == ST_STOP) || (next_state == ST_OPEN);
        end
    end

    // Which stop inputs took part in this stop
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            nc_seen <= 1'b0;
            ext_seen <= 1'b0;
        end else if (next_state == ST_RUN) begin
            nc_seen <= 1'b0;
            ext_seen <= 1'b0;
        end else if (state == ST_STOP) begin
            nc_seen <= nc_seen || nc_estop_i;
            ext_seen <= ext_seen || ext_estop_i;
        end
    end

    // Gate-off delay timer, in milliseconds
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || state != ST_STOP) begin
            tick_cnt <= '0;
            ms_cnt <= '0;
        end else if (tick_cnt == TICK_W'(TICK - 1)) begin
            tick_cnt <= '0;
            if (ms_cnt != '1) begin
                ms_cnt <= ms_cnt + 1'b1;
            end
        end else begin
            tick_cnt <= tick_cnt + 1'b1;
        end
    end

    // Ready drops only on the controller's confirmation
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ready_o <= 1'b0;
        end else if (next_state == ST_RUN && state != ST_RUN) begin
            ready_o <= 1'b1;
        end else if (confirm_drop) begin
            ready_o <= 1'b0;
        end
    end

    // Contactor driven by the owning axis only
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            contactor_on_o <= 1'b0;
        end else if (next_state == ST_RUN && state != ST_RUN) begin
            contactor_on_o <= wdata_i[CTRL_CONT_OWNER]; // Owner bit written with the restart
        end else if (open_now) begin
            contactor_on_o <= 1'b0;
        end
    end

    // Braking mode during a stop or a speed alarm
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            spindle_decel_o <= 1'b0;
            servo_decel_o <= 1'b0;
            servo_dyn_brake_o <= 1'b0;
        end else if (speed_alarm) begin
            spindle_decel_o <= 1'b1;
            servo_decel_o <= 1'b1;
            servo_dyn_brake_o <= 1'b0;
        end else if (state == ST_STOP || state == ST_OPEN) begin
            spindle_decel_o <= 1'b1;
            servo_decel_o <= ctrl[CTRL_SERVO_DECEL];
            servo_dyn_brake_o <= !ctrl[CTRL_SERVO_DECEL];
        end else begin
            spindle_decel_o <= 1'b0;
            servo_decel_o <= 1'b0;
            servo_dyn_brake_o <= 1'b0;
        end
    end

    // External stop broadcast and local indication
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            line_estop_o <= 1'b0;
            ext_estop_indication_o <= 1'b0;
        end else begin
            line_estop_o <= ext_estop_i;
            ext_estop_indication_o <= ext_estop_i && (next_state != ST_RUN) && (next_state != ST_OFF);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Limited-speed watch

    speed_limit_check #(
        .W(SPEED_W)
    ) u_check (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .enable_i(watch_on),
        .cmd_speed_i(cmd_speed_i),
        .fb_speed_i(fb_speed_i),
        .cmd_limit_i(cmd_limit),
        .fb_limit_i(fb_limit),
        .cmd_over_o(cmd_over),
        .fb_over_o(fb_over)
    );

    // Either checker trips the alarm
    assign speed_trip = cmd_over || fb_over || (watch_on && nc_overspeed_i);

    // Alarm cleared by a restart unless a trip is still present; torque off cleared by every restart
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            speed_alarm <= 1'b0;
            torque_off_function_o <= 1'b0;
        end else if (restart_req && !stop_req) begin
            speed_alarm <= speed_trip;
            torque_off_function_o <= 1'b0;
        end else begin
            speed_alarm <= speed_alarm || speed_trip;
            if (speed_alarm && motor_stopped_i) begin
                torque_off_function_o <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file and interrupt

    // Writable configuration
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl <= CTRL_RST[CTRL_W-1:1];
            servo_gate_off_delay <= DLY_RST;
            spindle_gate_off_delay <= DLY_RST;
            cmd_limit <= SPEED_W'(LIM_RST);
            fb_limit <= SPEED_W'(LIM_RST);
            irq_mask <= IRQ_MASK_RST;
        end else if (wr_i) begin
            case (addr_i)
                CTRL_ADDR: ctrl <= wdata_i[CTRL_W-1:1];
                SERVO_DLY_ADDR: servo_gate_off_delay <= wdata_i[DLY_W-1:0];
                SPINDLE_DLY_ADDR: spindle_gate_off_delay <= wdata_i[DLY_W-1:0];
                CMD_LIM_ADDR: cmd_limit <= wdata_i[SPEED_W-1:0];
                FB_LIM_ADDR: fb_limit <= wdata_i[SPEED_W-1:0];
                IRQ_MASK_ADDR: irq_mask <= wdata_i[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // Interrupt events
    always_comb begin
        irq_event = '0;
        irq_event[IRQ_ESTOP] = (state == ST_RUN) && stop_req;
        irq_event[IRQ_EXT_ONLY] = timeout && !nc_seen && !nc_estop_i;
        irq_event[IRQ_GATE_TMO] = timeout;
        irq_event[IRQ_SPEED] = speed_trip && !speed_alarm;
    end

    // Sticky status, write one to clear, set wins
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_stat <= '0;
            irq_o <= 1'b0;
        end else begin
            if (wr_i && addr_i == IRQ_STAT_ADDR) begin
                irq_stat <= (irq_stat & ~wdata_i[IRQ_W-1:0]) | irq_event;
            end else begin
                irq_stat <= irq_stat | irq_event;
            end
            irq_o <= |(irq_stat & irq_mask);
        end
    end

    // Read data, valid the cycle after the strobe only
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= '0;
            if (rd_i) begin
                case (addr_i)
                    CTRL_ADDR: rdata_o <= DATA_W'({ctrl, 1'b0});
                    SERVO_DLY_ADDR: rdata_o <= DATA_W'(servo_gate_off_delay);
                    SPINDLE_DLY_ADDR: rdata_o <= DATA_W'(spindle_gate_off_delay);
                    CMD_LIM_ADDR: rdata_o <= DATA_W'(cmd_limit);
                    FB_LIM_ADDR: rdata_o <= DATA_W'(fb_limit);
                    STATE_ADDR: rdata_o <= {ms_cnt, 8'h00, ext_seen, nc_seen,
                                            torque_off_function_o, speed_alarm,
                                            contactor_on_o, ready_o, state};
                    IRQ_STAT_ADDR: rdata_o <= DATA_W'(irq_stat);
                    IRQ_MASK_ADDR: rdata_o <= DATA_W'(irq_mask);
                    default: rdata_o <= '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_overspeed;
        watch_on && (cmd_over || fb_over);
    endsequence
    sequence s_forced_decel;
        speed_alarm ##1 (spindle_decel_o && servo_decel_o && !servo_dyn_brake_o);
    endsequence
    stop_entry_a: assert property (
        (state == ST_RUN && stop_req) |=> (state == ST_STOP && estop_o))
        else $error("stop not entered");
    normal_seq_a: assert property (
        confirm_drop |=> (!ready_o && !contactor_on_o && state == ST_OPEN))
        else $error("normal stop sequence wrong");
    brake_mode_a: assert property (
        (state == ST_STOP && !speed_alarm) |=>
        (spindle_decel_o && servo_dyn_brake_o == !servo_decel_o))
        else $error("braking mode wrong");
    ready_held_a: assert property (
        (state == ST_STOP && ready_o && !nc_seen && !nc_estop_i) |=> ready_o)
        else $error("ready dropped without controller");
    gate_timeout_a: assert property (
        timeout |=> (!contactor_on_o ##1 (state != ST_STOP)))
        else $error("gate-off timeout did not open");
    line_stop_a: assert property (
        ext_estop_i |=> line_estop_o)
        else $error("line stop not broadcast");
    ext_indication_a: assert property (
        (ext_estop_i && state == ST_STOP && !open_now) |=> ext_estop_indication_o)
        else $error("external stop indication missing");
    speed_alarm_a: assert property (
        s_overspeed |=> s_forced_decel)
        else $error("overspeed did not force decel");
    torque_cut_a: assert property (
        (speed_alarm && motor_stopped_i && !(restart_req && !stop_req))
        |=> torque_off_function_o)
        else $error("torque not removed");
    stop_latch_a: assert property (
        (state == ST_OPEN && (!restart_req || stop_req)) |=> state == ST_OPEN)
        else $error("stop latch released");
endmodule
`default_nettype wire

// [hw/safety_stop_pkg.sv]
// Constants, register map and state type of the safety stop sequencer
//
// What this block does
// - Enter emergency stop as soon as either redundant stop input opens.
// - Controller and external stop together run the controller-only stop sequence.
// - Spindles decelerate; servos dynamic-brake, or decelerate when configured.
// - Ready drops only after controller confirms all axes stopped; owner opens contactor.
// - Both stops present before all axes stop still give the normal sequence.
// - External stop alone puts every unit on the line into emergency stop.
// - The axis wired to the external stop shows an external-stop indication.
// - External stop alone never drops ready; contactor opens after gate-off delay.
// - Controller stop without confirmation opens contactor after maximum gate-off delay.
// - Door open with speed watch on: command and feedback speed stay within limits.
// - Drive or controller overspeed raises an alarm forcing controlled deceleration.
// - After a limited-speed stop the motor power is removed by torque off.
// - Torque off cuts motor energy inside the drive, no contactor action.
package safety_stop_pkg;

    // Register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte addresses
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] SERVO_DLY_ADDR = 8'h04;
    localparam logic [7:0] SPINDLE_DLY_ADDR = 8'h08;
    localparam logic [7:0] CMD_LIM_ADDR = 8'h0C;
    localparam logic [7:0] FB_LIM_ADDR = 8'h10;
    localparam logic [7:0] STATE_ADDR = 8'h14;
    localparam logic [7:0] IRQ_STAT_ADDR = 8'h18;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h1C;

    // Control register bits
    localparam int CTRL_RESTART = 0;
    localparam int CTRL_SERVO_DECEL = 1;
    localparam int CTRL_SPEED_WATCH = 2;
    localparam int CTRL_CONT_OWNER = 3;
    localparam int CTRL_W = 4;
    localparam logic [3:0] CTRL_RST = 4'h8;

    // Interrupt bits
    localparam int IRQ_ESTOP = 0;
    localparam int IRQ_EXT_ONLY = 1;
    localparam int IRQ_GATE_TMO = 2;
    localparam int IRQ_SPEED = 3;
    localparam int IRQ_W = 4;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;

    // Delay and limit fields, reset values
    localparam int DLY_W = 16;
    localparam logic [15:0] DLY_RST = 16'h0064;
    localparam logic [15:0] LIM_RST = 16'h0000;
    localparam int STATE_MS_LSB = 16;

    // Gate-off delay unit (1 ms) in clock cycles
    localparam int CLK_PERIOD_PS = 5000;
    localparam int DLY_UNIT_PS = 1000000000;
    localparam int TICK_CYCLES = DLY_UNIT_PS / CLK_PERIOD_PS;

    // Sequencer states, Gray along off-run-stop-open
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_RUN = 2'b01,
        ST_STOP = 2'b11,
        ST_OPEN = 2'b10
    } seq_state_t;

endpackage

// [hw/speed_limit_check.sv]
// Registered overspeed comparison for command and feedback speed
`timescale 1ns/100ps
`default_nettype none
module speed_limit_check #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Watch enable and speeds
    input wire logic enable_i,
    input wire logic [W-1:0] cmd_speed_i,
    input wire logic [W-1:0] fb_speed_i,
    input wire logic [W-1:0] cmd_limit_i,
    input wire logic [W-1:0] fb_limit_i,
    // Overspeed flags
    output logic cmd_over_o,
    output logic fb_over_o
);

    logic [1:0][W-1:0] speed;
    logic [1:0][W-1:0] limit;
    logic [1:0] over;

    assign speed = {fb_speed_i, cmd_speed_i};
    assign limit = {fb_limit_i, cmd_limit_i};

    // One comparator per speed channel
    for (genvar c = 0; c < 2; c++) begin : g_chan
        always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
                over[c] <= 1'b0;
            end else begin
                over[c] <= enable_i && (speed[c] > limit[c]);
            end
        end
    end

    assign cmd_over_o = over[0];
    assign fb_over_o = over[1];

endmodule
`default_nettype wire

// [verification/nc_controller_model.sv]
// Behavioural controller model driving the stop, standstill and speed lines
`timescale 1ns/100ps
`default_nettype none
module nc_controller_model #(
    parameter int SPEED_W = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Bench commands
    input wire logic stop_req_i,
    input wire logic confirm_en_i,
    input wire logic watch_en_i,
    input wire logic [SPEED_W-1:0] lim_i,
    input wire logic [SPEED_W-1:0] cmd_speed_i,
    input wire logic door_i,
    // Towards the drive
    output logic nc_estop_o,
    output logic all_axes_stopped_o,
    output logic nc_overspeed_o,
    output logic door_o
);
    logic [7:0] cnt;
    // Own stop line and door copy for the drive
    assign nc_estop_o = stop_req_i;
    assign door_o = door_i;
    // Standstill confirmed only some cycles after our own stop
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !stop_req_i) begin
            cnt <= 8'h00;
            all_axes_stopped_o <= 1'b0;
        end else begin
            cnt <= (cnt == 8'hFF) ? cnt : cnt + 8'h01;
            all_axes_stopped_o <= confirm_en_i && (cnt >= 8'h06);
        end
    end
    // Duplicate speed check on the controller side
    always_ff @(posedge clk_i) begin
        nc_overspeed_o <= rst_n_i && watch_en_i && door_i && (cmd_speed_i > lim_i);
    end
endmodule
`default_nettype wire

// [verification/test_safety_stop_sequencer.sv]
// Self-checking bench of the safety stop sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module test_safety_stop_sequencer;
    import safety_stop_pkg::*;
    localparam int TK = 8;
    logic clk_i, rst_n_i, wr_i, rd_i, ext_estop_i, motor_stopped_i, door_i;
    logic stop_req, confirm_en, watch_en;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i, rdata_o, v;
    logic [15:0] cmd_speed_i, fb_speed_i, mlim, lc, lf;
    logic nc_estop, stopped, nc_over, door_o, line_in;
    logic estop_o, line_estop_o, ext_ind, ready_o, cont_o, torque_o, sp_dec, sv_dec, sv_brk, irq_o;
    int n_fail = 0, check_count = 0, cycles = 0, t;
    bit al;
    ////////////////////////////////////////////////////////////////
    // Design and partner
    safety_stop_sequencer #(.TICK(TK), .SPEED_W(16)) safety_stop_sequencer_i (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .nc_estop_i(nc_estop), .ext_estop_i(ext_estop_i), .line_estop_i(line_in),
        .all_axes_stopped_i(stopped), .nc_overspeed_i(nc_over), .motor_stopped_i(motor_stopped_i),
        .door_state_input_i(door_o), .cmd_speed_i(cmd_speed_i), .fb_speed_i(fb_speed_i),
        .estop_o(estop_o), .line_estop_o(line_estop_o), .ext_estop_indication_o(ext_ind),
        .ready_o(ready_o), .contactor_on_o(cont_o), .torque_off_function_o(torque_o),
        .spindle_decel_o(sp_dec), .servo_decel_o(sv_dec), .servo_dyn_brake_o(sv_brk), .irq_o(irq_o));
    nc_controller_model #(.SPEED_W(16)) nc_controller_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .stop_req_i(stop_req), .confirm_en_i(confirm_en), .watch_en_i(watch_en), .lim_i(mlim),
        .cmd_speed_i(cmd_speed_i), .door_i(door_i), .nc_estop_o(nc_estop),
        .all_axes_stopped_o(stopped), .nc_overspeed_o(nc_over), .door_o(door_o));
    ////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////
    // Bus tasks and expectations
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic restart(input logic [3:0] c);
        wr(CTRL_ADDR, {28'h0, c | 4'h1});
        cyc(3);
        `CHK("ready", 1'b1, ready_o)
        `CHK("contactor", 1'b1, cont_o)
    endtask
    function automatic int open_time(input int a, input int b);
        return ((a > b) ? a : b) * TK;
    endfunction
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int sd, pd;
        {rst_n_i, wr_i, rd_i, ext_estop_i, motor_stopped_i, door_i, stop_req, confirm_en, watch_en} = '0;
        {addr_i, wdata_i, cmd_speed_i, fb_speed_i, mlim, line_in} = '0;
        void'($urandom(32'hFEF0));
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        // Reset values and an unmapped read
        rd(CTRL_ADDR, v); `CHK("ctrl", 32'h8, v)
        rd(SERVO_DLY_ADDR, v); `CHK("sdly", 32'h64, v)
        rd(SPINDLE_DLY_ADDR, v); `CHK("pdly", 32'h64, v)
        rd(FB_LIM_ADDR, v); `CHK("flim", 32'h0, v)
        rd(IRQ_MASK_ADDR, v); `CHK("mask", 32'h0, v)
        rd(8'h20, v); `CHK("unmapped", 32'h0, v)
        `CHK("ready off", 1'b0, ready_o)
        wr(IRQ_MASK_ADDR, 32'hF);
        // Modes: nc only, both together, staggered, ext only, nc without confirm, line only
        for (int m = 0; m < 6; m++) begin
            sd = 2 + $urandom % 4;
            pd = 2 + $urandom % 4;
            wr(SERVO_DLY_ADDR, sd);
            wr(SPINDLE_DLY_ADDR, pd);
            restart({2'b10, m[0], 1'b0});
            confirm_en <= (m < 3);
            stop_req <= (m != 3 && m != 5);
            ext_estop_i <= (m == 1 || m == 3);
            line_in <= (m == 5);
            cyc(2);
            `CHK("estop", 1'b1, estop_o)
            cyc(1);
            `CHK("sp decel", 1'b1, sp_dec)
            `CHK("sv decel", m[0], sv_dec)
            `CHK("sv brake", ~m[0], sv_brk)
            `CHK("line", (m == 1 || m == 3), line_estop_o)
            `CHK("ext ind", (m == 1 || m == 3), ext_ind)
            `CHK("ready hold", 1'b1, ready_o)
            if (m == 2)
                ext_estop_i <= 1'b1;
            if (m < 3) begin
                cyc(10);
                `CHK("ready drop", 1'b0, ready_o)
                `CHK("open", 1'b0, cont_o)
                wr(CTRL_ADDR, 32'h9);
                cyc(2);
                `CHK("latched", 1'b1, estop_o)
            end else begin
                t = open_time(sd, pd);
                cyc(t - 6);
                `CHK("early", 1'b1, cont_o)
                cyc(10);
                `CHK("late", 1'b0, cont_o)
                `CHK("ready kept", 1'b1, ready_o)
                rd(IRQ_STAT_ADDR, v);
                `CHK("tmo irq", 1'b1, v[IRQ_GATE_TMO])
                `CHK("ext irq", (m != 4), v[IRQ_EXT_ONLY])
                rd(STATE_ADDR, v);
                `CHK("state", {24'h0, (m == 3), (m == 4), 6'h06}, v)
                wr(IRQ_MASK_ADDR, 32'h0);
                cyc(2);
                `CHK("masked", 1'b0, irq_o)
                wr(IRQ_MASK_ADDR, 32'hF);
                cyc(2);
                `CHK("irq", 1'b1, irq_o)
            end
            {stop_req, ext_estop_i, line_in} <= '0;
            wr(IRQ_STAT_ADDR, 32'hF);
            cyc(2);
            `CHK("irq clr", 1'b0, irq_o)
        end
        // Speed watch: equal, cmd over, fb over, door shut, controller only
        lc = 16'd100 + 16'($urandom % 1000);
        lf = 16'd100 + 16'($urandom % 1000);
        wr(CMD_LIM_ADDR, {16'h0, lc});
        wr(FB_LIM_ADDR, {16'h0, lf});
        for (int k = 0; k < 5; k++) begin
            restart(4'hC);
            al = (k == 1 || k == 2 || k == 4);
            watch_en <= (k == 4);
            mlim <= lc - 16'd1;
            door_i <= (k != 3);
            cmd_speed_i <= (k == 1 || k == 3) ? lc + 16'd1 + 16'($urandom % 50) : lc;
            fb_speed_i <= (k == 2) ? lf + 16'd1 : lf;
            cyc(5);
            `CHK("alarm decel", al, sp_dec)
            `CHK("alarm sv decel", al, sv_dec)
            `CHK("alarm brake", 1'b0, sv_brk)
            motor_stopped_i <= 1'b1;
            cyc(3);
            `CHK("torque off", al, torque_o)
            `CHK("no contactor", 1'b1, cont_o)
            {watch_en, door_i, motor_stopped_i, cmd_speed_i, fb_speed_i} <= '0;
            wr(IRQ_STAT_ADDR, 32'hF);
        end
        complete_run();
    end
endmodule
`default_nettype wire
